/* core/scb_map.svh */
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH
// Notes on behaviour
// - address register bits 7:1 hold bus target address, writable by host
// - writing one to reset control bit 0 performs a soft reset
// - soft reset keeps the bus address, every other register defaults
// - soft reset bit clears itself after the reset, reads back zero
// - reset control bit 4 turns off the analog output
// - pin config bits 7:4 choose pin source: 0000,0011,0100,0110
// - pin config bits 3:2 choose pulls: off, pulldown, pullup, reserved
// - pin config bit 1 enables the pin input buffer
// - pin config bit 0 enables the pin driver, default one

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SCB_OFS_ADDR        8'h00
`define SCB_OFS_RESET       8'h01
`define SCB_OFS_PIN0        8'h02

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SCB_RST_SOFT_BIT    0
`define SCB_RST_ADIS_BIT    4
`define SCB_PIN0_DEFAULT    8'h05
`define SCB_MODE_SW_OUT     4'h0
`define SCB_MODE_CLK_LOSS   4'h3
`define SCB_MODE_CLK_DET    4'h4
`define SCB_MODE_POR        4'h6
`define SCB_PULL_NONE       2'h0
`define SCB_PULL_DOWN       2'h1
`define SCB_PULL_UP         2'h2
`define SCB_BITS_PER_BYTE   4'h8
`endif

/* core/scb_pkg.sv */
package scb_pkg;
    // pin configuration register layout
    typedef struct packed {
        logic [3:0] mode;
        logic [1:0] pulls;
        logic       in_buf_en;
        logic       drv_en;
    } scb_pin_cfg_t;

    // status levels that the pin may carry out
    typedef struct packed {
        logic sw_out;
        logic clk_loss;
        logic clk_present;
        logic por;
    } scb_pin_src_t;

    // pad controls for the general purpose pin
    typedef struct packed {
        logic out;
        logic oe;
        logic pullup_en;
        logic pulldown_en;
        logic in_buf_en;
    } scb_pad_t;

    typedef enum logic [2:0] {
        SCB_IDLE, SCB_ADDR, SCB_ACK, SCB_WR_BYTE, SCB_RD_BYTE, SCB_RD_ACK
    } scb_state_t;
endpackage : scb_pkg

/* core/scb_pin_drive.sv */
`timescale 1ns/1ns
`include "scb_map.svh"
module scb_pin_drive (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    // configuration and sources
    input  wire scb_pkg::scb_pin_cfg_t cfg,
    input  wire scb_pkg::scb_pin_src_t src,
    input  wire logic                  pin_in,
    // pad side
    output      scb_pkg::scb_pad_t     pad,
    output      logic                  pin_level
);
    import scb_pkg::*;

    scb_pad_t pad_ff;
    scb_pad_t nxt_pad;
    logic     level_ff;
    logic     nxt_level;

    // --------------------------------------------------------
    // pad control decode
    // --------------------------------------------------------
    // reserved codes drive low so the pin never floats to junk
    always_comb begin
        nxt_pad = '0;
        unique case (cfg.mode)
            `SCB_MODE_SW_OUT:   nxt_pad.out = src.sw_out;
            `SCB_MODE_CLK_LOSS: nxt_pad.out = src.clk_loss;
            `SCB_MODE_CLK_DET:  nxt_pad.out = src.clk_present;
            `SCB_MODE_POR:      nxt_pad.out = src.por;
            default:            nxt_pad.out = 1'b0;
        endcase
        nxt_pad.oe          = cfg.drv_en;
        nxt_pad.pulldown_en = (cfg.pulls == `SCB_PULL_DOWN);
        nxt_pad.pullup_en   = (cfg.pulls == `SCB_PULL_UP);
        nxt_pad.in_buf_en   = cfg.in_buf_en;
        // a disabled input buffer presents a quiet zero inside
        nxt_level = cfg.in_buf_en & pin_in;
    end

    // registered pad controls
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pad_ff   <= '0;
            level_ff <= 1'b0;
        end else begin
            pad_ff   <= nxt_pad;
            level_ff <= nxt_level;
        end
    end

    assign pad       = pad_ff;
    assign pin_level = level_ff;
endmodule : scb_pin_drive

/* core/scb_config_regs.sv */
`timescale 1ns/1ns
`include "scb_map.svh"
module scb_config_regs #(
    // arbitrary neutral power-up bus address
    parameter logic [6:0] TARGET_ADDR_DEFAULT = 7'h2A
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // serial management bus
    input  wire logic scl,
    input  wire logic sda_in,
    output      logic sda_out,
    output      logic sda_oe,
    input  wire logic bus_chip_select,
    // status sources for the pin
    input  wire logic software_output_bit,
    input  wire logic input_clock_loss,
    input  wire logic input_clock_present,
    input  wire logic power_on_reset_flag,
    // general purpose pin
    input  wire logic aux_pin0_in,
    output      logic aux_pin0_out,
    output      logic aux_pin0_driver_on,
    output      logic aux_pin0_pullup_en,
    output      logic aux_pin0_pulldown_en,
    output      logic aux_pin0_in_buf_en,
    output      logic aux_pin0_level,
    // analog side controls
    output      logic analog_output_disable,
    output      logic soft_reset_pulse
);
    import scb_pkg::*;

    // --------------------------------------------------------
    // state
    // --------------------------------------------------------
    scb_state_t   state_ff,    nxt_state;
    logic [7:0]   shift_ff,    nxt_shift;
    logic [3:0]   bitcnt_ff,   nxt_bitcnt;
    logic [7:0]   ptr_ff,      nxt_ptr;
    logic         ptr_set_ff,  nxt_ptr_set;
    logic         rw_ff,       nxt_rw;
    logic         ack_rd_ff,   nxt_ack_rd;
    logic         sda_oe_ff,   nxt_sda_oe;
    logic         scl_q_ff,    sda_q_ff;
    logic [6:0]   addr_ff,     nxt_addr;
    logic         adis_ff,     nxt_adis;
    logic         soft_ff,     nxt_soft;
    logic         pulse_ff,    nxt_pulse;
    scb_pin_cfg_t pin_cfg_ff,  nxt_pin_cfg;

    logic         start_det, stop_det, scl_rise, scl_fall;
    logic         wr_en;
    logic [7:0]   wr_data;
    logic [7:0]   rd_data;

    // --------------------------------------------------------
    // bus condition detection
    // --------------------------------------------------------
    // pins arrive synchronous, so one stage of history suffices
    assign start_det = scl & scl_q_ff & sda_q_ff & ~sda_in;
    assign stop_det  = scl & scl_q_ff & ~sda_q_ff & sda_in;
    assign scl_rise  = scl & ~scl_q_ff;
    assign scl_fall  = ~scl & scl_q_ff;

    // --------------------------------------------------------
    // read multiplexer
    // --------------------------------------------------------
    // pure decode of held values: a read changes nothing
    function automatic logic [7:0] reg_read(input logic [7:0] ofs);
        logic [7:0] v;
        v = 8'h00;
        unique case (ofs)
            `SCB_OFS_ADDR:  v = {addr_ff, 1'b0};
            `SCB_OFS_RESET: begin
                v[`SCB_RST_ADIS_BIT] = adis_ff;
                v[`SCB_RST_SOFT_BIT] = soft_ff;
            end
            `SCB_OFS_PIN0:  v = pin_cfg_ff;
            default:        v = 8'h00;
        endcase
        return v;
    endfunction : reg_read

    // a process, not an assign, so register updates are seen too
    always_comb begin
        rd_data = reg_read(ptr_ff);
    end

    // --------------------------------------------------------
    // protocol engine next state
    // --------------------------------------------------------
    always_comb begin
        nxt_state   = state_ff;
        nxt_shift   = shift_ff;
        nxt_bitcnt  = bitcnt_ff;
        nxt_ptr     = ptr_ff;
        nxt_ptr_set = ptr_set_ff;
        nxt_rw      = rw_ff;
        nxt_ack_rd  = ack_rd_ff;
        nxt_sda_oe  = sda_oe_ff;
        wr_en       = 1'b0;
        wr_data     = shift_ff;
        if (start_det) begin
            nxt_state  = SCB_ADDR;
            nxt_bitcnt = 4'h0;
            nxt_sda_oe = 1'b0;
        end else if (stop_det) begin
            nxt_state  = SCB_IDLE;
            nxt_sda_oe = 1'b0;
        end else begin
            unique case (state_ff)
                SCB_IDLE: nxt_sda_oe = 1'b0;
                SCB_ADDR: begin
                    if (scl_rise) begin
                        nxt_shift  = {shift_ff[6:0], sda_in};
                        nxt_bitcnt = bitcnt_ff + 4'h1;
                    end else if (scl_fall &&
                                 bitcnt_ff == `SCB_BITS_PER_BYTE) begin
                        // only a selected device answers its address
                        if (bus_chip_select &&
                            shift_ff[7:1] == addr_ff) begin
                            nxt_rw      = shift_ff[0];
                            nxt_ptr_set = 1'b0;
                            nxt_sda_oe  = 1'b1;
                            nxt_state   = SCB_ACK;
                        end else begin
                            nxt_state = SCB_IDLE;
                        end
                    end
                end
                SCB_ACK: begin
                    if (scl_fall) begin
                        nxt_bitcnt = 4'h0;
                        if (rw_ff) begin
                            // first data bit goes out on this edge
                            nxt_shift  = rd_data;
                            nxt_sda_oe = ~rd_data[7];
                            nxt_state  = SCB_RD_BYTE;
                        end else begin
                            nxt_sda_oe = 1'b0;
                            nxt_state  = SCB_WR_BYTE;
                        end
                    end
                end
                SCB_WR_BYTE: begin
                    if (scl_rise) begin
                        nxt_shift  = {shift_ff[6:0], sda_in};
                        nxt_bitcnt = bitcnt_ff + 4'h1;
                    end else if (scl_fall &&
                                 bitcnt_ff == `SCB_BITS_PER_BYTE) begin
                        // first byte sets the pointer, later ones write
                        if (!ptr_set_ff) begin
                            nxt_ptr     = shift_ff;
                            nxt_ptr_set = 1'b1;
                        end else begin
                            wr_en   = 1'b1;
                            nxt_ptr = ptr_ff + 8'h01;
                        end
                        nxt_sda_oe = 1'b1;
                        nxt_state  = SCB_ACK;
                    end
                end
                SCB_RD_BYTE: begin
                    if (scl_rise) begin
                        nxt_bitcnt = bitcnt_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (bitcnt_ff == `SCB_BITS_PER_BYTE) begin
                            nxt_sda_oe = 1'b0;
                            nxt_ptr    = ptr_ff + 8'h01;
                            nxt_state  = SCB_RD_ACK;
                        end else begin
                            nxt_shift  = {shift_ff[6:0], 1'b0};
                            nxt_sda_oe = ~shift_ff[6];
                        end
                    end
                end
                SCB_RD_ACK: begin
                    if (scl_rise) begin
                        nxt_ack_rd = ~sda_in;
                    end else if (scl_fall) begin
                        nxt_bitcnt = 4'h0;
                        if (ack_rd_ff) begin
                            nxt_shift  = rd_data;
                            nxt_sda_oe = ~rd_data[7];
                            nxt_state  = SCB_RD_BYTE;
                        end else begin
                            nxt_state = SCB_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // protocol engine registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_ff   <= SCB_IDLE;
            shift_ff   <= 8'h00;
            bitcnt_ff  <= 4'h0;
            ptr_ff     <= 8'h00;
            ptr_set_ff <= 1'b0;
            rw_ff      <= 1'b0;
            ack_rd_ff  <= 1'b0;
            sda_oe_ff  <= 1'b0;
            scl_q_ff   <= 1'b1;
            sda_q_ff   <= 1'b1;
        end else begin
            state_ff   <= nxt_state;
            shift_ff   <= nxt_shift;
            bitcnt_ff  <= nxt_bitcnt;
            ptr_ff     <= nxt_ptr;
            ptr_set_ff <= nxt_ptr_set;
            rw_ff      <= nxt_rw;
            ack_rd_ff  <= nxt_ack_rd;
            sda_oe_ff  <= nxt_sda_oe;
            scl_q_ff   <= scl;
            sda_q_ff   <= sda_in;
        end
    end

    // --------------------------------------------------------
    // register file next state
    // --------------------------------------------------------
    // soft reset waits for the stop so the write still gets its ack
    always_comb begin
        nxt_addr    = addr_ff;
        nxt_adis    = adis_ff;
        nxt_soft    = soft_ff;
        nxt_pin_cfg = pin_cfg_ff;
        nxt_pulse   = 1'b0;
        if (wr_en) begin
            unique case (ptr_ff)
                `SCB_OFS_ADDR:  nxt_addr = wr_data[7:1];
                `SCB_OFS_RESET: begin
                    nxt_adis = wr_data[`SCB_RST_ADIS_BIT];
                    nxt_soft = wr_data[`SCB_RST_SOFT_BIT];
                end
                `SCB_OFS_PIN0:  nxt_pin_cfg = wr_data;
                default:        nxt_addr = addr_ff;
            endcase
        end
        if (soft_ff && stop_det) begin
            // everything but the address returns to power-up values
            nxt_adis    = 1'b0;
            nxt_pin_cfg = `SCB_PIN0_DEFAULT;
            nxt_soft    = 1'b0;
            nxt_pulse   = 1'b1;
        end
    end

    // register file storage
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            addr_ff    <= TARGET_ADDR_DEFAULT;
            adis_ff    <= 1'b0;
            soft_ff    <= 1'b0;
            pulse_ff   <= 1'b0;
            pin_cfg_ff <= `SCB_PIN0_DEFAULT;
        end else begin
            addr_ff    <= nxt_addr;
            adis_ff    <= nxt_adis;
            soft_ff    <= nxt_soft;
            pulse_ff   <= nxt_pulse;
            pin_cfg_ff <= nxt_pin_cfg;
        end
    end

    // --------------------------------------------------------
    // pin driver
    // --------------------------------------------------------
    scb_pin_src_t pin_src;
    scb_pad_t     pin_pad;

    assign pin_src = '{sw_out:      software_output_bit,
                       clk_loss:    input_clock_loss,
                       clk_present: input_clock_present,
                       por:         power_on_reset_flag};

    scb_pin_drive u_pin0 (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .cfg       (pin_cfg_ff),
        .src       (pin_src),
        .pin_in    (aux_pin0_in),
        .pad       (pin_pad),
        .pin_level (aux_pin0_level)
    );

    // --------------------------------------------------------
    // outputs
    // --------------------------------------------------------
    // open drain: the data line is only ever pulled low
    assign sda_out               = 1'b0;
    assign sda_oe                = sda_oe_ff;
    assign aux_pin0_out          = pin_pad.out;
    assign aux_pin0_driver_on    = pin_pad.oe;
    assign aux_pin0_pullup_en    = pin_pad.pullup_en;
    assign aux_pin0_pulldown_en  = pin_pad.pulldown_en;
    assign aux_pin0_in_buf_en    = pin_pad.in_buf_en;
    assign analog_output_disable = adis_ff;
    assign soft_reset_pulse      = pulse_ff;
endmodule : scb_config_regs

/* verification/scb_host_model.sv */
`timescale 1ns/1ns
module scb_host_model (
    // clock
    input  wire logic clk_sys,
    // bus wires, data is open drain with a pull-up
    input  wire logic sda_line,
    output      logic scl,
    output      logic sda_low,
    output      logic chip_sel
);
    // ------------------------------------------------------------
    // bus master: bit, byte and transfer tasks
    // ------------------------------------------------------------
    logic sel_ok = 1'b1;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        chip_sel = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    // data moves only while the clock is low, sampled mid high phase
    task automatic put_bit(input logic b, output logic got);
        sda_low <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(2);
        got = sda_line;
        tick(2);
        scl <= 1'b0;
        tick(1);
    endtask : put_bit
    task automatic put_byte(input logic [7:0] v, input logic last,
                            output logic [7:0] got, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i], g);
            got[i] = g;
        end
        put_bit(last, g);
        ack = ~g;
    endtask : put_byte
    // select is raised before start so the target sees it all along
    task automatic start;
        chip_sel <= sel_ok;
        sda_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(1);
    endtask : start
    task automatic stop;
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(6);
        chip_sel <= 1'b0;
        // let an edge pass so a following start never hits this step
        tick(1);
    endtask : stop
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, dat,
                      output logic ok);
        logic [7:0] g;
        logic       a0, a1, a2;
        start;
        put_byte({dev, 1'b0}, 1'b1, g, a0);
        put_byte(ptr, 1'b1, g, a1);
        put_byte(dat, 1'b1, g, a2);
        stop;
        ok = a0 && a1 && a2;
    endtask : wr
    // the last read byte is refused on purpose to end the transfer
    task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                      output logic [7:0] dat, output logic ok);
        logic [7:0] g;
        logic       a0, a1, a2, a3;
        start;
        put_byte({dev, 1'b0}, 1'b1, g, a0);
        put_byte(ptr, 1'b1, g, a1);
        start;
        put_byte({dev, 1'b1}, 1'b1, g, a2);
        put_byte(8'hFF, 1'b1, dat, a3);
        stop;
        ok = a0 && a1 && a2;
    endtask : rd
endmodule : scb_host_model

/* verification/scb_config_regs_sva.sv */
`timescale 1ns/1ns
module scb_config_regs_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // bus
    input wire logic scl,
    input wire logic sda_oe,
    input wire logic bus_chip_select,
    // pin sources
    input wire logic software_output_bit,
    input wire logic input_clock_loss,
    input wire logic input_clock_present,
    input wire logic power_on_reset_flag,
    // pad and controls
    input wire logic aux_pin0_in,
    input wire logic aux_pin0_out,
    input wire logic aux_pin0_driver_on,
    input wire logic aux_pin0_pullup_en,
    input wire logic aux_pin0_pulldown_en,
    input wire logic aux_pin0_in_buf_en,
    input wire logic aux_pin0_level,
    input wire logic analog_output_disable,
    input wire logic soft_reset_pulse
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    logic any_src;
    // pin output can only be high when some source was high
    assign any_src = software_output_bit || input_clock_loss ||
                     input_clock_present || power_on_reset_flag;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    pull_excl_a: assert property (
        !(aux_pin0_pullup_en && aux_pin0_pulldown_en))
        else $error("both pulls enabled");
    level_gate_a: assert property (
        aux_pin0_level == ($past(aux_pin0_in) && aux_pin0_in_buf_en))
        else $error("pin level not gated by input buffer");
    src_out_a: assert property (
        aux_pin0_out |-> $past(any_src))
        else $error("pin high with no source high");
    ack_sel_a: assert property (
        $rose(sda_oe) |-> bus_chip_select)
        else $error("bus driven while not selected");
    oe_hold_a: assert property (
        $changed(sda_oe) |-> !$past(scl) && !scl)
        else $error("data changed while bus clock high");
    pulse_once_a: assert property (
        soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse longer than one cycle");
    srst_dflt_a: assert property (
        soft_reset_pulse |-> ##3 (!analog_output_disable &&
        aux_pin0_driver_on && aux_pin0_pulldown_en && !aux_pin0_in_buf_en))
        else $error("soft reset left controls off default");
    ana_rise_a: assert property (
        $rose(analog_output_disable) |-> !scl && !soft_reset_pulse)
        else $error("analog disable set outside a write");
    rst_dflt_a: assert property (
        $rose(reset_n) |-> ##3 (aux_pin0_driver_on &&
        aux_pin0_pulldown_en && !aux_pin0_pullup_en))
        else $error("pin controls off default after reset");
    cover property (soft_reset_pulse);
    cover property ($rose(analog_output_disable));
    cover property (aux_pin0_level);
    cover property (aux_pin0_pullup_en);
endmodule : scb_config_regs_chk

bind scb_config_regs scb_config_regs_chk u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .scl(scl), .sda_oe(sda_oe),
    .bus_chip_select(bus_chip_select),
    .software_output_bit(software_output_bit),
    .input_clock_loss(input_clock_loss),
    .input_clock_present(input_clock_present),
    .power_on_reset_flag(power_on_reset_flag),
    .aux_pin0_in(aux_pin0_in), .aux_pin0_out(aux_pin0_out),
    .aux_pin0_driver_on(aux_pin0_driver_on),
    .aux_pin0_pullup_en(aux_pin0_pullup_en),
    .aux_pin0_pulldown_en(aux_pin0_pulldown_en),
    .aux_pin0_in_buf_en(aux_pin0_in_buf_en),
    .aux_pin0_level(aux_pin0_level),
    .analog_output_disable(analog_output_disable),
    .soft_reset_pulse(soft_reset_pulse)
);

/* verification/serializer_config_registers_test.sv */
`timescale 1ns/1ns
`include "scb_map.svh"
module serializer_config_registers_test;
    import scb_pkg::*;
    // ------------------------------------------------------------
    // bench, stimulus and checks
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_A = 7'h35; // arbitrary start address
    localparam logic [6:0] ADDR_B = 7'h1C; // arbitrary new address
    localparam logic [3:0] MODES [5] = '{`SCB_MODE_SW_OUT,
        `SCB_MODE_CLK_LOSS, `SCB_MODE_CLK_DET, `SCB_MODE_POR, 4'h7};
    logic       clk_sys, reset_n, sda_out, sda_oe, rd_ok;
    logic       sw_bit, clk_loss, clk_ok, por_flag, pin_in;
    logic       pin_out, drv_on, pu_en, pd_en, ib_en, pin_lvl;
    logic       an_dis, srst;
    logic [7:0] rd_val;
    wire        scl, sda_low, chip_sel;
    // open drain data line with pull-up
    wire        sda_line = !(sda_low || (sda_oe && !sda_out));
    int         failures = 0;
    int         checked = 0;
    int         pulses = 0;
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    scb_config_regs #(.TARGET_ADDR_DEFAULT(ADDR_A)) DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .scl(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .bus_chip_select(chip_sel), .software_output_bit(sw_bit),
        .input_clock_loss(clk_loss), .input_clock_present(clk_ok),
        .power_on_reset_flag(por_flag), .aux_pin0_in(pin_in),
        .aux_pin0_out(pin_out), .aux_pin0_driver_on(drv_on),
        .aux_pin0_pullup_en(pu_en), .aux_pin0_pulldown_en(pd_en),
        .aux_pin0_in_buf_en(ib_en), .aux_pin0_level(pin_lvl),
        .analog_output_disable(an_dis), .soft_reset_pulse(srst));
    scb_host_model host (.clk_sys(clk_sys), .sda_line(sda_line),
        .scl(scl), .sda_low(sda_low), .chip_sel(chip_sel));
    // count soft reset pulses to prove exactly one per request
    always @(posedge clk_sys) begin
        if (srst === 1'b1) begin
            pulses <= pulses + 1;
        end
    end
    task automatic chk(input logic [7:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [6:0] dev, input logic [7:0] ptr, exp);
        host.rd(dev, ptr, rd_val, rd_ok);
        chk({7'h0, rd_ok}, 8'h01, "read ack");
        chk(rd_val, exp, "read value");
    endtask : rchk
    task automatic wreg(input logic [6:0] dev, input logic [7:0] ptr, dat);
        host.wr(dev, ptr, dat, rd_ok);
        chk({7'h0, rd_ok}, 8'h01, "write ack");
    endtask : wreg
    task automatic end_sim;
        if (failures == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    // a full run needs about 8500 cycles; allow plenty of slack
    initial begin
        repeat (40000) @(posedge clk_sys);
        failures++;
        end_sim;
    end
    initial begin
        reset_n = 1'b0;
        {sw_bit, clk_loss, clk_ok, por_flag, pin_in} = 5'h00;
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk({3'h0, drv_on, pd_en, pu_en, ib_en, an_dis}, 8'h18, "pads");
        rchk(ADDR_A, `SCB_OFS_ADDR, {ADDR_A, 1'b0});
        rchk(ADDR_A, `SCB_OFS_RESET, 8'h00);
        rchk(ADDR_A, `SCB_OFS_PIN0, `SCB_PIN0_DEFAULT);
        // reserved bits of the reset register are dropped on write
        wreg(ADDR_A, `SCB_OFS_RESET, 8'hFE);
        rchk(ADDR_A, `SCB_OFS_RESET, 8'h10);
        chk({7'h0, an_dis}, 8'h01, "analog off");
        // every source code and every pull code, input buffer kept off
        for (int i = 0; i < 5; i++) begin
            wreg(ADDR_A, `SCB_OFS_PIN0, {MODES[i], i[1:0], 2'b01});
            {sw_bit, clk_loss, clk_ok, por_flag} <= i < 4 ? 4'h8 >> i : 4'hF;
            repeat (3) @(posedge clk_sys);
            chk({4'h0, pin_out, pu_en, pd_en, drv_on}, {4'h0, i < 4,
                i[1:0] == 2'h2, i[1:0] == 2'h1, 1'b1}, "pin mode");
            rchk(ADDR_A, `SCB_OFS_PIN0, {MODES[i], i[1:0], 2'b01});
        end
        // pin used as input: driver off, buffer on
        wreg(ADDR_A, `SCB_OFS_PIN0, 8'h02);
        pin_in <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({5'h0, drv_on, ib_en, pin_lvl}, 8'h03, "pin input");
        wreg(ADDR_A, 8'h03, 8'hA5);
        rchk(ADDR_A, 8'h03, 8'h00);
        // new bus address, lowest bit written as zero
        wreg(ADDR_A, `SCB_OFS_ADDR, {ADDR_B, 1'b0});
        rchk(ADDR_B, `SCB_OFS_ADDR, {ADDR_B, 1'b0});
        host.rd(ADDR_A, `SCB_OFS_ADDR, rd_val, rd_ok);
        chk({7'h0, rd_ok}, 8'h00, "old address acked");
        host.sel_ok = 1'b0;
        host.rd(ADDR_B, `SCB_OFS_ADDR, rd_val, rd_ok);
        chk({7'h0, rd_ok}, 8'h00, "acked unselected");
        host.sel_ok = 1'b1;
        // soft reset with analog off and pin configured away from default
        wreg(ADDR_B, `SCB_OFS_RESET, 8'h11);
        repeat (4) @(posedge clk_sys);
        chk(pulses[7:0], 8'h01, "soft reset pulses");
        chk({6'h0, an_dis, drv_on}, 8'h01, "controls after reset");
        rchk(ADDR_B, `SCB_OFS_ADDR, {ADDR_B, 1'b0});
        rchk(ADDR_B, `SCB_OFS_RESET, 8'h00);
        rchk(ADDR_B, `SCB_OFS_PIN0, `SCB_PIN0_DEFAULT);
        end_sim;
    end
endmodule : serializer_config_registers_test
